// [rtl/mtw_walker.sv]
// hardware table walker that decodes descriptors and fills the lookup buffer
// How it works
// - level-one address: base 31:14 plus va 31:20
// - level-one type: invalid, coarse, section, fine
// - section physical address from descriptor bits 31:20
// - section bits 3:2 give cache treatment
// - level-one bits 8:5 select one of 16 domains
// - section permission field is bits 11:10
// - coarse base bits 31:10, then level-two fetch
// - fine base bits 31:12, then level-two fetch
// - section domain checked before address is produced; permission passed on in the fill
// - level-two type: invalid, large, small, tiny
// - page bits 3:2 give cache treatment
// - page address bits per size from descriptor
// - tiny page has one permission, no sub-pages
// - differing sub-permissions load only accessed sub-page
// - domain setting: no access, client, reserved, manager
`timescale 1ns/10ps
module mtw_walker #(
	parameter int ADDR_W = 32
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic walk_req,
	input wire logic [ADDR_W-1:0] walk_va,
	input wire logic [31:0] table_base_pointer,
	input wire logic [31:0] domain_access_ctrl,
	output logic walk_busy_ff,
	output logic mem_req_ff,
	output logic [31:0] mem_addr_ff,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output logic fill_valid_ff,
	output mtw_pkg::mtw_entry_type fill_entry_ff,
	output logic fault_valid_ff,
	output mtw_pkg::mtw_fault_type fault_kind_ff,
	output logic [3:0] fault_domain_ff
);
	typedef enum logic [1:0] {ST_IDLE, ST_L1, ST_L2} mtw_state_type;

	mtw_state_type state_ff;
	logic [31:0] va_ff;
	logic [31:0] l1_ff;
	logic [1:0] dom_mode;
	logic dom_fault;
	logic [31:0] l2_addr;
	logic [1:0] sub_sel;
	logic [3:0] sub_same;
	mtw_pkg::mtw_entry_type nxt_entry;

	// domain setting of the level-one descriptor: just returned in ST_L1, latched copy in l1_ff otherwise
	always_comb begin
		logic [3:0] d;
		d = 4'h0;
		if (state_ff == ST_L1) begin
			d = mem_rdata[mtw_pkg::DOM_HI:mtw_pkg::DOM_LO];
		end else begin
			d = l1_ff[mtw_pkg::DOM_HI:mtw_pkg::DOM_LO];
		end
		dom_mode = domain_access_ctrl[{d, 1'b0} +: 2];
	end

	// reserved setting is treated as no access
	assign dom_fault = (dom_mode == mtw_pkg::DOM_NOACC) || (dom_mode == mtw_pkg::DOM_RSVD);

	// level-two address from the level-one descriptor on the read data, not the latched copy
	always_comb begin
		if (mem_rdata[1:0] == mtw_pkg::L1_COARSE) begin
			l2_addr = {mem_rdata[31:mtw_pkg::CRS_BASE_LO],
				va_ff[mtw_pkg::CRS_IDX_HI:mtw_pkg::CRS_IDX_LO], mtw_pkg::WORD_ZERO};
		end else begin
			l2_addr = {mem_rdata[31:mtw_pkg::FINE_BASE_LO],
				va_ff[mtw_pkg::FINE_IDX_HI:mtw_pkg::FINE_IDX_LO], mtw_pkg::WORD_ZERO};
		end
	end

	// sub-page selection and uniformity of the four permission fields
	assign sub_sel = (mem_rdata[1:0] == mtw_pkg::L2_LARGE) ?
		va_ff[mtw_pkg::LRG_SUB_HI:mtw_pkg::LRG_SUB_LO] :
		va_ff[mtw_pkg::SML_SUB_HI:mtw_pkg::SML_SUB_LO];
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sub
			assign sub_same[gi] = mem_rdata[mtw_pkg::SUBAP_LO + 2*gi +: 2] ==
				mem_rdata[mtw_pkg::SUBAP_LO +: 2];
		end
	endgenerate

	// fill entry built from whichever descriptor is on the read data
	always_comb begin
		nxt_entry = '0;
		nxt_entry.va = va_ff;
		nxt_entry.cb = mem_rdata[mtw_pkg::CB_HI:mtw_pkg::CB_LO];
		nxt_entry.check_ap = (dom_mode == mtw_pkg::DOM_CLIENT);
		if (state_ff == ST_L1) begin
			nxt_entry.domain = mem_rdata[mtw_pkg::DOM_HI:mtw_pkg::DOM_LO];
			nxt_entry.size = mtw_pkg::SZ_SECTION;
			nxt_entry.ap = mem_rdata[mtw_pkg::SEC_AP_HI:mtw_pkg::SEC_AP_LO];
			nxt_entry.pa = {mem_rdata[31:mtw_pkg::SEC_PA_LO],
				va_ff[mtw_pkg::SEC_PA_LO-1:0]};
		end else begin
			nxt_entry.domain = l1_ff[mtw_pkg::DOM_HI:mtw_pkg::DOM_LO];
			case (mem_rdata[1:0])
				mtw_pkg::L2_LARGE: begin
					nxt_entry.pa = {mem_rdata[31:mtw_pkg::LRG_PA_LO],
						va_ff[mtw_pkg::LRG_PA_LO-1:0]};
					nxt_entry.size = (&sub_same) ? mtw_pkg::SZ_LARGE : mtw_pkg::SZ_LARGE_SUB;
					nxt_entry.ap = mem_rdata[mtw_pkg::SUBAP_LO + 2*sub_sel +: 2];
				end
				mtw_pkg::L2_SMALL: begin
					nxt_entry.pa = {mem_rdata[31:mtw_pkg::SML_PA_LO],
						va_ff[mtw_pkg::SML_PA_LO-1:0]};
					nxt_entry.size = (&sub_same) ? mtw_pkg::SZ_SMALL : mtw_pkg::SZ_SMALL_SUB;
					nxt_entry.ap = mem_rdata[mtw_pkg::SUBAP_LO + 2*sub_sel +: 2];
				end
				default: begin
					// single permission field, never split
					nxt_entry.pa = {mem_rdata[31:mtw_pkg::TNY_PA_LO],
						va_ff[mtw_pkg::TNY_PA_LO-1:0]};
					nxt_entry.size = mtw_pkg::SZ_TINY;
					nxt_entry.ap = mem_rdata[mtw_pkg::TNY_AP_HI:mtw_pkg::TNY_AP_LO];
				end
			endcase
		end
	end

	// walk sequencing and memory fetches
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			va_ff <= mtw_pkg::ZERO32;
			l1_ff <= mtw_pkg::ZERO32;
			mem_req_ff <= 1'b0;
			mem_addr_ff <= mtw_pkg::ZERO32;
			walk_busy_ff <= 1'b0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (walk_req) begin
						state_ff <= ST_L1;
						va_ff <= 32'(walk_va);
						walk_busy_ff <= 1'b1;
						mem_req_ff <= 1'b1;
						mem_addr_ff <= {table_base_pointer[mtw_pkg::TB_HI:mtw_pkg::TB_LO],
							walk_va[mtw_pkg::L1_IDX_HI:mtw_pkg::L1_IDX_LO],
							mtw_pkg::WORD_ZERO};
					end
				end
				ST_L1: begin
					if (mem_ack) begin
						l1_ff <= mem_rdata;
						case (mem_rdata[1:0])
							mtw_pkg::L1_COARSE, mtw_pkg::L1_FINE: begin
								if (dom_fault) begin
									state_ff <= ST_IDLE;
									mem_req_ff <= 1'b0;
									walk_busy_ff <= 1'b0;
								end else begin
									state_ff <= ST_L2;
									mem_addr_ff <= l2_addr;
								end
							end
							default: begin
								state_ff <= ST_IDLE;
								mem_req_ff <= 1'b0;
								walk_busy_ff <= 1'b0;
							end
						endcase
					end
				end
				ST_L2: begin
					if (mem_ack) begin
						state_ff <= ST_IDLE;
						mem_req_ff <= 1'b0;
						walk_busy_ff <= 1'b0;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
					mem_req_ff <= 1'b0;
					walk_busy_ff <= 1'b0;
				end
			endcase
		end
	end

	// results: a fill or a fault, one-cycle pulses
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fill_valid_ff <= 1'b0;
			fill_entry_ff <= '0;
			fault_valid_ff <= 1'b0;
			fault_kind_ff <= mtw_pkg::FLT_NONE;
			fault_domain_ff <= 4'h0;
		end else begin
			fill_valid_ff <= 1'b0;
			fault_valid_ff <= 1'b0;
			if (mem_ack && state_ff == ST_L1) begin
				fault_domain_ff <= mem_rdata[mtw_pkg::DOM_HI:mtw_pkg::DOM_LO];
				if (mem_rdata[1:0] == mtw_pkg::L1_INVALID) begin
					fault_valid_ff <= 1'b1;
					fault_kind_ff <= mtw_pkg::FLT_TRANS_SEC;
				end else if (dom_fault) begin
					// domain checked before any address leaves for a section
					fault_valid_ff <= 1'b1;
					fault_kind_ff <= (mem_rdata[1:0] == mtw_pkg::L1_SECTION) ?
						mtw_pkg::FLT_DOMAIN_SEC : mtw_pkg::FLT_DOMAIN_PAGE;
				end else if (mem_rdata[1:0] == mtw_pkg::L1_SECTION) begin
					fill_valid_ff <= 1'b1;
					fill_entry_ff <= nxt_entry;
				end
			end else if (mem_ack && state_ff == ST_L2) begin
				fault_domain_ff <= l1_ff[mtw_pkg::DOM_HI:mtw_pkg::DOM_LO];
				if (mem_rdata[1:0] == mtw_pkg::L2_INVALID) begin
					fault_valid_ff <= 1'b1;
					fault_kind_ff <= mtw_pkg::FLT_TRANS_PAGE;
				end else begin
					fill_valid_ff <= 1'b1;
					fill_entry_ff <= nxt_entry;
				end
			end
		end
	end

	// checks
	property p_l1_addr;
		@(posedge core_clk) disable iff (rst)
		(state_ff == ST_IDLE && walk_req) |=> mem_req_ff && walk_busy_ff && state_ff == ST_L1 &&
			mem_addr_ff[1:0] == 2'b00;
	endproperty
	a_l1_addr: assert property (p_l1_addr) else $error("l1 address wrong");

	property p_l1_form;
		@(posedge core_clk) disable iff (rst)
		(state_ff == ST_IDLE && walk_req) |=> mem_addr_ff ==
			{$past(table_base_pointer[31:14]), $past(walk_va[31:20]), 2'b00};
	endproperty
	a_l1_form: assert property (p_l1_form) else $error("l1 address not base and index");

	property p_inval_l1;
		@(posedge core_clk) disable iff (rst)
		(state_ff == ST_L1 && mem_ack && mem_rdata[1:0] == 2'b00) |=>
			fault_valid_ff && fault_kind_ff == mtw_pkg::FLT_TRANS_SEC && !fill_valid_ff;
	endproperty
	a_inval_l1: assert property (p_inval_l1) else $error("invalid l1 no fault");

	property p_sec_pa;
		@(posedge core_clk) disable iff (rst)
		(state_ff == ST_L1 && mem_ack && mem_rdata[1:0] == 2'b10 && !dom_fault) |=>
			fill_valid_ff && fill_entry_ff.pa[31:20] == $past(mem_rdata[31:20]) &&
			fill_entry_ff.ap == $past(mem_rdata[11:10]) &&
			fill_entry_ff.cb == $past(mem_rdata[3:2]);
	endproperty
	a_sec_pa: assert property (p_sec_pa) else $error("section fill wrong");

	property p_sec_dom;
		@(posedge core_clk) disable iff (rst)
		(state_ff == ST_L1 && mem_ack && dom_fault) |=>
			fault_valid_ff && !fill_valid_ff && !walk_busy_ff;
	endproperty
	a_sec_dom: assert property (p_sec_dom) else $error("fill despite domain fault");

	property p_l2_fetch;
		@(posedge core_clk) disable iff (rst)
		(state_ff == ST_L1 && mem_ack && mem_rdata[0] && !dom_fault) |=>
			state_ff == ST_L2 && mem_req_ff && mem_addr_ff[1:0] == 2'b00;
	endproperty
	a_l2_fetch: assert property (p_l2_fetch) else $error("no level-two fetch");

	property p_inval_l2;
		@(posedge core_clk) disable iff (rst)
		(state_ff == ST_L2 && mem_ack && mem_rdata[1:0] == 2'b00) |=>
			fault_valid_ff && fault_kind_ff == mtw_pkg::FLT_TRANS_PAGE;
	endproperty
	a_inval_l2: assert property (p_inval_l2) else $error("invalid l2 no fault");

	property p_tiny;
		@(posedge core_clk) disable iff (rst)
		(state_ff == ST_L2 && mem_ack && mem_rdata[1:0] == 2'b11) |=>
			fill_entry_ff.size == mtw_pkg::SZ_TINY &&
			fill_entry_ff.pa[31:10] == $past(mem_rdata[31:10]);
	endproperty
	a_tiny: assert property (p_tiny) else $error("tiny page fill wrong");

	property p_large;
		@(posedge core_clk) disable iff (rst)
		(state_ff == ST_L2 && mem_ack && mem_rdata[1:0] == 2'b01) |=>
			fill_entry_ff.pa[31:16] == $past(mem_rdata[31:16]) &&
			fill_entry_ff.cb == $past(mem_rdata[3:2]) &&
			((fill_entry_ff.size == mtw_pkg::SZ_LARGE) == $past(&sub_same));
	endproperty
	a_large: assert property (p_large) else $error("large page fill wrong");
endmodule

// [rtl/mtw_pkg.sv]
// constants and carrier types for the descriptor table walker
package mtw_pkg;
	localparam int VA_W = 32;
	localparam int TB_HI = 31;
	localparam int TB_LO = 14;
	localparam int L1_IDX_HI = 31;
	localparam int L1_IDX_LO = 20;
	localparam int CRS_BASE_LO = 10;
	localparam int FINE_BASE_LO = 12;
	localparam int CRS_IDX_HI = 19;
	localparam int CRS_IDX_LO = 12;
	localparam int FINE_IDX_HI = 19;
	localparam int FINE_IDX_LO = 10;
	localparam int SEC_PA_LO = 20;
	localparam int LRG_PA_LO = 16;
	localparam int SML_PA_LO = 12;
	localparam int TNY_PA_LO = 10;
	localparam int CB_HI = 3;
	localparam int CB_LO = 2;
	localparam int DOM_HI = 8;
	localparam int DOM_LO = 5;
	localparam int SEC_AP_HI = 11;
	localparam int SEC_AP_LO = 10;
	localparam int TNY_AP_HI = 5;
	localparam int TNY_AP_LO = 4;
	localparam int SUBAP_LO = 4;
	localparam int LRG_SUB_HI = 15;
	localparam int LRG_SUB_LO = 14;
	localparam int SML_SUB_HI = 11;
	localparam int SML_SUB_LO = 10;
	localparam int N_DOM = 16;
	localparam logic [1:0] L1_INVALID = 2'h0;
	localparam logic [1:0] L1_COARSE = 2'h1;
	localparam logic [1:0] L1_SECTION = 2'h2;
	localparam logic [1:0] L1_FINE = 2'h3;
	localparam logic [1:0] L2_INVALID = 2'h0;
	localparam logic [1:0] L2_LARGE = 2'h1;
	localparam logic [1:0] L2_SMALL = 2'h2;
	localparam logic [1:0] L2_TINY = 2'h3;
	localparam logic [1:0] DOM_NOACC = 2'h0;
	localparam logic [1:0] DOM_CLIENT = 2'h1;
	localparam logic [1:0] DOM_RSVD = 2'h2;
	localparam logic [1:0] DOM_MANAGER = 2'h3;
	localparam logic [1:0] WORD_ZERO = 2'h0;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;

	typedef enum logic [2:0] {
		FLT_NONE, FLT_TRANS_SEC, FLT_TRANS_PAGE, FLT_DOMAIN_SEC, FLT_DOMAIN_PAGE
	} mtw_fault_type;

	typedef enum logic [2:0] {
		SZ_SECTION, SZ_LARGE, SZ_LARGE_SUB, SZ_SMALL, SZ_SMALL_SUB, SZ_TINY
	} mtw_size_type;

	// one lookup buffer fill entry
	typedef struct packed {
		logic [31:0] va;
		logic [31:0] pa;
		mtw_size_type size;
		logic [1:0] cb;
		logic [3:0] domain;
		logic [1:0] ap;
		logic check_ap;
	} mtw_entry_type;
endpackage

// [tb/mtw_mem_model.sv]
// table memory that answers walker fetches after a set latency
`timescale 1ns/10ps
module mtw_mem_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic [3:0] lat,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic [31:0] mem [logic [31:0]];
	logic [31:0] last_ff;
	logic [3:0] cnt_ff;
	always_ff @(posedge core_clk) begin
		if (rst || !mem_req || mem_ack) begin
			cnt_ff <= 4'h0;
			mem_ack <= 1'h0;
			if (rst) begin
				last_ff <= 32'h0000_0000;
			end
		end else if (cnt_ff == lat) begin
			mem_ack <= 1'h1;
			last_ff <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
		end else begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end
	// stale data is inverted so a read outside the ack cycle shows up
	assign mem_rdata = mem_ack ? last_ff : ~last_ff;
endmodule

// [tb/mtw_walker_bench.sv]
// bench for the table walker: builds tables, runs walks, checks fills and faults
`timescale 1ns/10ps
module mtw_walker_bench;
	logic core_clk = 1'h0;
	logic rst = 1'h1;
	logic walk_req = 1'h0;
	logic [31:0] walk_va = 32'h0000_0000;
	logic [31:0] tbp = 32'h1234_4000;
	logic [31:0] dac = 32'h5555_5875;
	logic [3:0] lat = 4'h0;
	logic walk_busy_ff, mem_req_ff, mem_ack, fill_valid_ff, fault_valid_ff;
	logic [31:0] mem_addr_ff, mem_rdata;
	mtw_pkg::mtw_entry_type fill_entry_ff;
	mtw_pkg::mtw_fault_type fault_kind_ff;
	logic [3:0] fault_domain_ff;
	logic [31:0] cur_va = 32'h0000_0000;
	int n_errors = 0;
	int comparisons = 0;
	always #5 core_clk = ~core_clk;
	mtw_walker u_mtw_walker (.core_clk(core_clk), .rst(rst), .walk_req(walk_req),
		.walk_va(walk_va), .table_base_pointer(tbp), .domain_access_ctrl(dac),
		.walk_busy_ff(walk_busy_ff), .mem_req_ff(mem_req_ff), .mem_addr_ff(mem_addr_ff),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .fill_valid_ff(fill_valid_ff),
		.fill_entry_ff(fill_entry_ff), .fault_valid_ff(fault_valid_ff),
		.fault_kind_ff(fault_kind_ff), .fault_domain_ff(fault_domain_ff));
	mtw_mem_model u_mem (.core_clk(core_clk), .rst(rst), .mem_req(mem_req_ff),
		.mem_addr(mem_addr_ff), .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	task automatic stop_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic cmp(logic [47:0] got, logic [47:0] exp, string what);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	function automatic logic [31:0] l1a(logic [31:0] va);
		return {tbp[31:14], va[31:20], 2'h0};
	endfunction
	function automatic logic [31:0] crs(logic [21:0] b, logic [3:0] d);
		return {b, 1'h0, d, 1'h1, 2'h0, mtw_pkg::L1_COARSE};
	endfunction
	function automatic logic [31:0] fin(logic [19:0] b, logic [3:0] d);
		return {b, 3'h0, d, 1'h1, 2'h0, mtw_pkg::L1_FINE};
	endfunction
	// one walk; poke repeats the request while busy, which must be ignored
	task automatic walk(logic [31:0] va, logic [3:0] l, logic poke);
		int i;
		@(negedge core_clk);
		cur_va = va;
		lat = l;
		walk_va = va;
		walk_req = 1'h1;
		@(negedge core_clk);
		walk_req = poke;
		walk_va = ~va;
		@(negedge core_clk);
		walk_req = 1'h0;
		for (i = 0; i < 60 && !fill_valid_ff && !fault_valid_ff; i++) begin
			cmp(walk_busy_ff, 1'h1, "busy");
			@(negedge core_clk);
		end
		if (i == 60) begin
			n_errors++;
			stop_test();
		end
		cmp(walk_busy_ff, 1'h0, "idle");
	endtask
	task automatic chk_fill(logic [31:0] pa, mtw_pkg::mtw_size_type sz, logic [1:0] cb,
		logic [3:0] dom, logic [1:0] ap, logic ck);
		cmp({fill_valid_ff, fault_valid_ff}, 2'h2, "fill pulse");
		cmp(fill_entry_ff.va, cur_va, "va");
		cmp({fill_entry_ff.pa, fill_entry_ff.size, fill_entry_ff.cb, fill_entry_ff.domain,
			fill_entry_ff.ap, fill_entry_ff.check_ap}, {pa, sz, cb, dom, ap, ck}, "entry");
	endtask
	task automatic chk_fault(mtw_pkg::mtw_fault_type k, logic [3:0] dom, logic use_dom);
		cmp({fill_valid_ff, fault_valid_ff}, 2'h1, "fault pulse");
		cmp(fault_kind_ff, k, "fault kind");
		if (use_dom) begin
			cmp(fault_domain_ff, dom, "fault domain");
		end
	endtask
	initial begin
		repeat (12) @(negedge core_clk);
		rst = 1'h0;
		cmp({walk_busy_ff, mem_req_ff, fill_valid_ff, fault_valid_ff}, 4'h0, "reset");
		u_mem.mem[l1a(32'h0011_2345)] = {12'h5a5, 8'h00, 2'h2, 1'h0, 4'h3, 1'h1, 2'h3, 2'h2};
		walk(32'h0011_2345, 4'h0, 1'h0);
		chk_fill(32'h5a51_2345, mtw_pkg::SZ_SECTION, 2'h3, 4'h3, 2'h2, 1'h1);
		// manager domain, slow memory, request repeated while busy
		u_mem.mem[l1a(32'h0021_0000)] = {12'h777, 8'h00, 2'h1, 1'h0, 4'h2, 1'h1, 2'h1, 2'h2};
		walk(32'h0021_0000, 4'h3, 1'h1);
		chk_fill(32'h7771_0000, mtw_pkg::SZ_SECTION, 2'h1, 4'h2, 2'h1, 1'h0);
		u_mem.mem[l1a(32'h0030_0000)] = 32'hffff_fffc;
		walk(32'h0030_0000, 4'h1, 1'h0);
		chk_fault(mtw_pkg::FLT_TRANS_SEC, 4'h0, 1'h0);
		// domain 4 is no-access, domain 5 reserved
		for (int d = 4; d < 6; d++) begin
			u_mem.mem[l1a({12'(d), 20'h0_0000})] = {12'h100, 8'h00, 2'h3, 1'h0, 4'(d), 1'h1,
				2'h3, 2'h2};
			walk({12'(d), 20'h0_0000}, 4'h0, 1'h0);
			chk_fault(mtw_pkg::FLT_DOMAIN_SEC, 4'(d), 1'h1);
		end
		u_mem.mem[l1a(32'h0041_2abc)] = crs(22'h00_1000, 4'h3);
		u_mem.mem[{22'h00_1000, 8'h12, 2'h0}] = {20'habcde, 8'hff, 2'h2, mtw_pkg::L2_SMALL};
		walk(32'h0041_2abc, 4'h1, 1'h0);
		chk_fill(32'habcd_eabc, mtw_pkg::SZ_SMALL, 2'h2, 4'h3, 2'h3, 1'h1);
		u_mem.mem[l1a(32'h0052_8123)] = crs(22'h00_2000, 4'h3);
		for (int k = 0; k < 16; k++) begin
			u_mem.mem[{22'h00_2000, 4'h2, 4'(k), 2'h0}] = {16'hbeef, 4'h0, 8'he4, 4'h5};
		end
		walk(32'h0052_8123, 4'h2, 1'h0);
		chk_fill(32'hbeef_8123, mtw_pkg::SZ_LARGE_SUB, 2'h1, 4'h3, 2'h2, 1'h1);
		u_mem.mem[l1a(32'h0060_1abc)] = fin(20'h0_3000, 4'h2);
		u_mem.mem[{20'h0_3000, 10'h006, 2'h0}] = {22'h15_5555, 4'h0, 2'h1, 2'h0, 2'h3};
		walk(32'h0060_1abc, 4'h0, 1'h0);
		chk_fill(32'h5555_56bc, mtw_pkg::SZ_TINY, 2'h0, 4'h2, 2'h1, 1'h0);
		u_mem.mem[l1a(32'h0070_0c00)] = fin(20'h0_4000, 4'h3);
		for (int k = 0; k < 4; k++) begin
			u_mem.mem[{20'h0_4000, 8'h00, 2'(k), 2'h0}] = {20'h12345, 8'h1b, 4'h6};
		end
		walk(32'h0070_0c00, 4'h2, 1'h0);
		chk_fill(32'h1234_5c00, mtw_pkg::SZ_SMALL_SUB, 2'h1, 4'h3, 2'h0, 1'h1);
		u_mem.mem[l1a(32'h0080_0000)] = crs(22'h00_3000, 4'h3);
		u_mem.mem[{22'h00_3000, 8'h00, 2'h0}] = 32'hffff_fffc;
		walk(32'h0080_0000, 4'h1, 1'h0);
		chk_fault(mtw_pkg::FLT_TRANS_PAGE, 4'h3, 1'h1);
		u_mem.mem[l1a(32'h0090_0000)] = crs(22'h00_3000, 4'h4);
		walk(32'h0090_0000, 4'h0, 1'h0);
		chk_fault(mtw_pkg::FLT_DOMAIN_PAGE, 4'h4, 1'h1);
		stop_test();
	end
endmodule
